//--- hdl/pwr_pkg.sv
package pwr_pkg;

    // ------------------------------------------------------------
    // Register map (byte addresses)
    // ------------------------------------------------------------
    localparam int ADDR_W = 12;
    localparam logic [11:0] ADDR_POWER_CTRL = 12'hf80;
    localparam logic [11:0] ADDR_RESET_CAUSE = 12'hff0;

    // ------------------------------------------------------------
    // Field positions and values
    // ------------------------------------------------------------
    localparam int BIT_POR = 7;
    localparam int BIT_STOP = 6;
    localparam int BIT_WDT = 5;
    localparam int BIT_EXT = 4;
    localparam int BIT_BO_DIS = 4;
    localparam int BIT_ADC_DIS = 2;
    localparam int BIT_COMP_DIS = 1;
    localparam logic [7:0] POWER_CTRL_RESET = 8'h80;
    localparam logic [3:0] FLAGS_POR = 4'h8;
    localparam logic [3:0] FLAGS_EXT = 4'h1;
    localparam logic [3:0] FLAGS_WDT_RST = 4'h2;
    localparam logic [3:0] FLAGS_SMR_GPIO = 4'h4;
    localparam logic [3:0] FLAGS_SMR_WDT = 4'h6;
    localparam logic [3:0] FLAGS_CLEAR = 4'h0;
    localparam logic [3:0] RESERVED_READ = 4'h0;

    // ------------------------------------------------------------
    // Power modes, one-hot
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        MODE_ACTIVE = 3'b001,
        MODE_HALT = 3'b010,
        MODE_STOP = 3'b100
    } mode_t;

    // Inputs from outside the clock domain, as one group
    typedef struct packed {
        logic brownout_reset;
        logic watchdog_timeout;
        logic gpio_wake;
        logic debug_pin;
        logic reset_pin_n;
    } async_in_t;

    localparam int ASYNC_W = 5;
    localparam logic [4:0] ASYNC_IDLE = 5'h03;

endpackage

//--- hdl/level_sync.sv
`timescale 1ns/10ps
// Two-stage synchroniser with edge detection on the settled level
module level_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] IDLE = '0
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] level,
    output logic [WIDTH-1:0] rise,
    output logic [WIDTH-1:0] fall
);
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] last;

    initial
    begin
        if (WIDTH < 1)
        begin
            $error("level_sync: WIDTH must be at least 1");
        end
    end

    // Capture chain; only the second stage reads the first
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            meta <= IDLE;
            level <= IDLE;
            last <= IDLE;
        end
        else
        begin
            meta <= async_in;
            level <= meta;
            last <= level;
        end
    end

    assign rise = level & ~last;
    assign fall = ~level & last;
endmodule // level_sync

//--- hdl/periph_gate.sv
`timescale 1ns/10ps
// Clock gate enable for one peripheral
module periph_gate (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic disable_bit,
    input wire logic in_stop,
    output logic gate_en
);
    // Off when disabled by software or when the device is in stop
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            gate_en <= 1'b0;
        end
        else
        begin
            gate_en <= ~disable_bit & ~in_stop;
        end
    end
endmodule // periph_gate

//--- hdl/reset_power_ctrl.sv
`timescale 1ns/10ps
module reset_power_ctrl
    import pwr_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic cpu_stop_exec,
    input wire logic cpu_halt_exec,
    input wire logic irq_pending,
    input wire logic debugger_reset_req,
    input wire logic wdt_reset_mode,
    input wire logic wdt_enable,
    input wire logic wdt_osc_enable,
    input wire logic brownout_option,
    input wire logic brownout_stop_option,
    input wire async_in_t pins_in,
    output mode_t power_mode,
    output logic cpu_run,
    output logic sys_clk_en,
    output logic osc_en,
    output logic crystal_pins_release,
    output logic wdt_osc_run,
    output logic wdt_logic_run,
    output logic brownout_active,
    output logic adc_clk_en,
    output logic comp_clk_en,
    output logic system_reset,
    output logic [7:0] watchdog_control,
    output logic watchdog_control_wr
);

    // ------------------------------------------------------------
    // Synchronised pins and events
    // ------------------------------------------------------------
    logic [ASYNC_W-1:0] pin_level;
    logic [ASYNC_W-1:0] pin_rise;
    logic [ASYNC_W-1:0] pin_fall;
    async_in_t lvl;
    async_in_t up;
    async_in_t down;

    level_sync #(
        .WIDTH(ASYNC_W),
        .IDLE(ASYNC_IDLE)
    ) u_sync (
        .clk(pclk),
        .rst_n(presetn),
        .async_in(pins_in),
        .level(pin_level),
        .rise(pin_rise),
        .fall(pin_fall)
    );

    assign lvl = pin_level;
    assign up = pin_rise;
    assign down = pin_fall;

    // Event decode
    logic in_stop;
    logic in_halt;
    logic ev_ext_reset;
    logic ev_debug_low;
    logic ev_wdt;
    logic ev_gpio;
    logic ev_brownout;
    logic ev_dbg_req;
    logic smr_wdt;
    logic smr_gpio;
    logic wdt_sys_reset;
    logic wdt_irq_only;
    logic any_sys_reset;

    assign in_stop = (power_mode == MODE_STOP);
    assign in_halt = (power_mode == MODE_HALT);
    assign ev_ext_reset = down.reset_pin_n;
    assign ev_debug_low = down.debug_pin & in_stop;
    assign ev_wdt = up.watchdog_timeout & wdt_enable;
    assign ev_gpio = up.gpio_wake & in_stop;
    assign ev_brownout = up.brownout_reset;
    assign ev_dbg_req = debugger_reset_req;
    assign smr_wdt = ev_wdt & in_stop;
    assign smr_gpio = ev_gpio & ~ev_wdt;
    assign wdt_sys_reset = ev_wdt & ~in_stop & wdt_reset_mode;
    assign wdt_irq_only = ev_wdt & ~in_stop & ~wdt_reset_mode;
    assign any_sys_reset = ev_ext_reset | ev_debug_low | ev_brownout
                         | ev_dbg_req | wdt_sys_reset;

    // ------------------------------------------------------------
    // APB slave
    // ------------------------------------------------------------
    logic bus_access;
    logic bus_done;
    logic hit_power;
    logic hit_cause;
    logic rd_cause_done;

    assign bus_access = psel & penable;
    assign bus_done = bus_access & pready;
    assign hit_power = (paddr == ADDR_POWER_CTRL);
    assign hit_cause = (paddr == ADDR_RESET_CAUSE);
    assign rd_cause_done = bus_done & ~pwrite & hit_cause;

    logic [7:0] power_ctrl;
    logic [3:0] cause_flags;

    // One wait state; answer held for one cycle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= '0;
        end
        else if (bus_access && !pready)
        begin
            pready <= 1'b1;
            pslverr <= ~(hit_power | hit_cause);
            prdata <= '0;
            if (!pwrite && hit_power)
            begin
                prdata <= {24'h000000, power_ctrl};
            end
            else if (!pwrite && hit_cause)
            begin
                // Flags as held before this read
                prdata <= {24'h000000, cause_flags, RESERVED_READ};
            end
        end
        else
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
    end

    // Writes at the shared address go to watchdog control
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            watchdog_control <= '0;
            watchdog_control_wr <= 1'b0;
        end
        else
        begin
            watchdog_control_wr <= 1'b0;
            if (bus_done && pwrite && hit_cause && pstrb[0])
            begin
                watchdog_control <= pwdata[7:0];
                watchdog_control_wr <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // Peripheral power control register
    // ------------------------------------------------------------
    // Only presetn and brown-out reach it; other resets leave it
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            power_ctrl <= POWER_CTRL_RESET;
        end
        else if (ev_brownout)
        begin
            power_ctrl <= POWER_CTRL_RESET;
        end
        else if (bus_done && pwrite && hit_power && pstrb[0])
        begin
            // Reserved bits stored as written
            power_ctrl <= pwdata[7:0];
        end
    end

    // ------------------------------------------------------------
    // Reset cause flags
    // ------------------------------------------------------------
    logic [3:0] next_cause_flags;

    // Events in the clearing cycle override the read clear; one in the wait cycle is cleared unread
    always_comb
    begin
        next_cause_flags = cause_flags;
        if (rd_cause_done)
        begin
            next_cause_flags = FLAGS_CLEAR;
        end
        if (ev_brownout || ev_dbg_req || ev_debug_low)
        begin
            next_cause_flags = FLAGS_POR;
        end
        else if (ev_ext_reset)
        begin
            next_cause_flags = FLAGS_EXT;
        end
        else if (smr_wdt)
        begin
            next_cause_flags = FLAGS_SMR_WDT;
        end
        else if (smr_gpio)
        begin
            next_cause_flags = FLAGS_SMR_GPIO;
        end
        else if (wdt_sys_reset)
        begin
            next_cause_flags = FLAGS_WDT_RST;
        end
        else if (wdt_irq_only)
        begin
            // Watchdog set, power-on and stop cleared
            next_cause_flags[BIT_WDT-4] = 1'b1;
            next_cause_flags[BIT_STOP-4] = 1'b0;
            next_cause_flags[BIT_POR-4] = 1'b0;
        end
    end

    // Power-on leaves only the power-on flag
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cause_flags <= FLAGS_POR;
        end
        else
        begin
            cause_flags <= next_cause_flags;
        end
    end

    // ------------------------------------------------------------
    // Power mode sequencer
    // ------------------------------------------------------------
    mode_t next_mode;
    logic halt_exit;
    logic stop_exit;

    assign halt_exit = irq_pending | ev_wdt | any_sys_reset;
    assign stop_exit = smr_wdt | ev_gpio | ev_ext_reset | ev_debug_low
                     | ev_brownout;

    always_comb
    begin
        next_mode = power_mode;
        unique case (power_mode)
            MODE_ACTIVE:
            begin
                if (any_sys_reset)
                begin
                    next_mode = MODE_ACTIVE;
                end
                else if (cpu_stop_exec)
                begin
                    next_mode = MODE_STOP;
                end
                else if (cpu_halt_exec)
                begin
                    next_mode = MODE_HALT;
                end
            end
            MODE_HALT:
            begin
                if (halt_exit)
                begin
                    next_mode = MODE_ACTIVE;
                end
            end
            MODE_STOP:
            begin
                if (stop_exit)
                begin
                    next_mode = MODE_ACTIVE;
                end
            end
            default:
            begin
                next_mode = MODE_ACTIVE;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            power_mode <= MODE_ACTIVE;
        end
        else
        begin
            power_mode <= next_mode;
        end
    end

    // ------------------------------------------------------------
    // Clock, oscillator and analog enables
    // ------------------------------------------------------------
    logic next_stop;
    logic next_halt;

    assign next_stop = (next_mode == MODE_STOP);
    assign next_halt = (next_mode == MODE_HALT);

    // Derived from the coming mode so outputs track it from the first edge after reset
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cpu_run <= 1'b0;
            sys_clk_en <= 1'b0;
            osc_en <= 1'b0;
            crystal_pins_release <= 1'b0;
            wdt_osc_run <= 1'b0;
            wdt_logic_run <= 1'b0;
            brownout_active <= 1'b0;
            system_reset <= 1'b0;
        end
        else
        begin
            cpu_run <= ~next_stop & ~next_halt;
            sys_clk_en <= ~next_stop;
            osc_en <= ~next_stop;
            crystal_pins_release <= next_stop;
            wdt_osc_run <= wdt_osc_enable;
            wdt_logic_run <= wdt_enable;
            // Both the option and the register must enable it
            brownout_active <= brownout_option & ~power_ctrl[BIT_BO_DIS]
                             & (~next_stop | brownout_stop_option);
            system_reset <= any_sys_reset;
        end
    end

    // Analog peripheral gates
    periph_gate u_adc_gate (
        .clk(pclk),
        .rst_n(presetn),
        .disable_bit(power_ctrl[BIT_ADC_DIS]),
        .in_stop(next_stop),
        .gate_en(adc_clk_en)
    );

    periph_gate u_comp_gate (
        .clk(pclk),
        .rst_n(presetn),
        .disable_bit(power_ctrl[BIT_COMP_DIS]),
        .in_stop(next_stop),
        .gate_en(comp_clk_en)
    );

endmodule // reset_power_ctrl

//--- sim/reset_power_ctrl_assertions.sv
`timescale 1ns/10ps
// ----
// Bus and power-mode checks
// ----
module reset_power_ctrl_checker
    import pwr_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic cpu_stop_exec,
    input wire logic irq_pending,
    input wire logic wdt_enable,
    input wire logic wdt_osc_enable,
    input wire logic brownout_stop_option,
    input wire mode_t power_mode,
    input wire logic cpu_run,
    input wire logic sys_clk_en,
    input wire logic osc_en,
    input wire logic crystal_pins_release,
    input wire logic wdt_osc_run,
    input wire logic wdt_logic_run,
    input wire logic brownout_active,
    input wire logic adc_clk_en,
    input wire logic comp_clk_en
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    // Bus phases and mode steps
    sequence s_req;
        psel && !penable ##1 psel && penable && !pready;
    endsequence
    sequence s_cause_rd;
        pready && psel && !pwrite && paddr == ADDR_RESET_CAUSE;
    endsequence
    sequence s_stop_go;
        power_mode == MODE_ACTIVE && cpu_stop_exec;
    endsequence

    AST_ANSWER: assert property (s_req |=> pready)
        else $error("no answer one cycle after access");
    AST_LOW_ZERO: assert property (s_cause_rd |-> prdata[3:0] == RESERVED_READ)
        else $error("reserved cause bits not zero");
    AST_STOP_ENTER: assert property (s_stop_go |=> power_mode == MODE_STOP)
        else $error("stop not entered");
    AST_STOP_GATES: assert property (power_mode == MODE_STOP |->
        !cpu_run && !sys_clk_en && !osc_en && !adc_clk_en && !comp_clk_en)
        else $error("clock still enabled in stop");
    AST_STOP_PINS: assert property (power_mode == MODE_STOP |-> crystal_pins_release)
        else $error("crystal pins held in stop");
    AST_WDT_STOP: assert property (power_mode == MODE_STOP |->
        wdt_logic_run == wdt_enable && wdt_osc_run == wdt_osc_enable)
        else $error("watchdog state wrong in stop");
    AST_BO_STOP: assert property (power_mode == MODE_STOP && !brownout_stop_option
        |-> !brownout_active)
        else $error("brown-out active in stop");
    AST_HALT_KEEP: assert property (power_mode == MODE_HALT |->
        !cpu_run && sys_clk_en && osc_en)
        else $error("halt clocks wrong");
    AST_HALT_IRQ: assert property (power_mode == MODE_HALT && irq_pending
        |=> power_mode == MODE_ACTIVE)
        else $error("halt not left on interrupt");
endmodule // reset_power_ctrl_checker

bind reset_power_ctrl reset_power_ctrl_checker reset_power_ctrl_checker_inst (.pclk, .presetn,
    .psel, .penable, .pwrite, .paddr, .prdata, .pready, .cpu_stop_exec, .irq_pending,
    .wdt_enable, .wdt_osc_enable, .brownout_stop_option, .power_mode, .cpu_run, .sys_clk_en,
    .osc_en, .crystal_pins_release, .wdt_osc_run, .wdt_logic_run, .brownout_active,
    .adc_clk_en, .comp_clk_en);

//--- sim/tb_reset_power_ctrl.sv
`timescale 1ns/10ps
module tb_reset_power_ctrl
    import pwr_pkg::*;
;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic [ADDR_W-1:0] paddr;
    logic [31:0] pwdata, prdata;
    logic stop_go, halt_go, irq, dbg_rst, wdt_mode, cpu_run, sys_en, osc_en, xtal;
    logic wosc, wrun, bo_act, adc_en, comp_en, sys_rst, wctl_wr;
    logic [7:0] wctl, rd;
    async_in_t pins;
    mode_t mode;
    int n_errors = 0;
    int n_compared = 0;
    int n_rst = 0;
    int n_wctl = 0;

    // Count one-cycle pulses so they can be compared later
    always @(posedge pclk)
    begin
        if (sys_rst === 1'b1)
            n_rst <= n_rst + 1;
        if (wctl_wr === 1'b1)
            n_wctl <= n_wctl + 1;
    end

    reset_power_ctrl reset_power_ctrl_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .cpu_stop_exec(stop_go),
        .cpu_halt_exec(halt_go), .irq_pending(irq), .debugger_reset_req(dbg_rst),
        .wdt_reset_mode(wdt_mode), .wdt_enable(1'b1), .wdt_osc_enable(1'b1),
        .brownout_option(1'b1), .brownout_stop_option(1'b0), .pins_in(pins),
        .power_mode(mode), .cpu_run(cpu_run), .sys_clk_en(sys_en), .osc_en(osc_en),
        .crystal_pins_release(xtal), .wdt_osc_run(wosc), .wdt_logic_run(wrun),
        .brownout_active(bo_act), .adc_clk_en(adc_en), .comp_clk_en(comp_en),
        .system_reset(sys_rst), .watchdog_control(wctl), .watchdog_control_wr(wctl_wr));

    // Clock source
    initial
    begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end

    // ----
    // Bus, pin and compare tasks
    // ----
    task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        // Wait for the answer; the loop ends once pready is seen high, or the hang guard stops the run
        do
        begin
            @(posedge pclk);
        end
        while (pready !== 1'b1);
        rd = prdata[7:0];
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        n_compared++;
        if (g !== e)
        begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic rchk(input logic [11:0] a, input logic [7:0] e);
        apb(1'b0, a, 8'h00);
        chk("rdata", e, rd);
    endtask

    // Toggle one async pin for four cycles, then let it settle
    task automatic pin(input int i);
        pins[i] <= ~pins[i];
        repeat (4) @(posedge pclk);
        pins[i] <= ~pins[i];
        repeat (8) @(posedge pclk);
    endtask

    task automatic go(input logic s, input logic h);
        @(posedge pclk);
        stop_go <= s;
        halt_go <= h;
        @(posedge pclk);
        stop_go <= 1'b0;
        halt_go <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic end_of_test();
        $display("compared %0d mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // Hang guard
    initial
    begin
        #300000;
        n_errors++;
        end_of_test();
    end

    // ----
    // Test sequence
    // ----
    initial
    begin
        presetn = 1'b0;
        {psel, penable, pwrite, stop_go, halt_go, irq, dbg_rst} = '0;
        wdt_mode = 1'b1;
        paddr = '0;
        pwdata = '0;
        pins = ASYNC_IDLE;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        repeat (3) @(posedge pclk);
        rchk(ADDR_RESET_CAUSE, 8'h80);
        rchk(ADDR_RESET_CAUSE, 8'h00);
        rchk(ADDR_POWER_CTRL, POWER_CTRL_RESET);
        $display("power-on test done");
        apb(1'b1, ADDR_POWER_CTRL, 8'h96);
        rchk(ADDR_POWER_CTRL, 8'h96);
        chk("adc_en", 8'h0, adc_en);
        chk("comp_en", 8'h0, comp_en);
        chk("bo_act", 8'h0, bo_act);
        apb(1'b1, ADDR_POWER_CTRL, 8'h84);
        rchk(ADDR_POWER_CTRL, 8'h84);
        chk("adc_en", 8'h0, adc_en);
        chk("comp_en", 8'h1, comp_en);
        chk("bo_act", 8'h1, bo_act);
        apb(1'b0, 12'h004, 8'h00);
        chk("slverr", 8'h1, err);
        apb(1'b1, ADDR_RESET_CAUSE, 8'h5a);
        rchk(ADDR_RESET_CAUSE, 8'h00);
        chk("wctl", 8'h5a, wctl);
        chk("wctl_wr", 8'h01, n_wctl[7:0]);
        $display("register test done");
        pin(0);
        rchk(ADDR_RESET_CAUSE, 8'h10);
        chk("sys_rst", 8'h01, n_rst[7:0]);
        rchk(ADDR_POWER_CTRL, 8'h84);
        pin(3);
        rchk(ADDR_RESET_CAUSE, 8'h20);
        $display("plain reset test done");
        go(1'b1, 1'b0);
        chk("mode", MODE_STOP, mode);
        chk("xtal", 8'h1, xtal);
        chk("bo_act", 8'h0, bo_act);
        chk("wrun", 8'h1, wrun);
        pin(2);
        chk("mode", MODE_ACTIVE, mode);
        rchk(ADDR_RESET_CAUSE, 8'h40);
        go(1'b1, 1'b0);
        pin(3);
        rchk(ADDR_RESET_CAUSE, 8'h60);
        go(1'b1, 1'b0);
        pin(1);
        rchk(ADDR_RESET_CAUSE, 8'h80);
        dbg_rst <= 1'b1;
        @(posedge pclk);
        dbg_rst <= 1'b0;
        repeat (4) @(posedge pclk);
        rchk(ADDR_RESET_CAUSE, 8'h80);
        $display("stop test done");
        go(1'b0, 1'b1);
        chk("mode", MODE_HALT, mode);
        chk("sys_en", 8'h1, sys_en);
        irq <= 1'b1;
        repeat (2) @(posedge pclk);
        irq <= 1'b0;
        chk("mode", MODE_ACTIVE, mode);
        wdt_mode <= 1'b0;
        go(1'b0, 1'b1);
        pin(3);
        chk("mode", MODE_ACTIVE, mode);
        rchk(ADDR_RESET_CAUSE, 8'h20);
        pin(4);
        rchk(ADDR_RESET_CAUSE, 8'h80);
        rchk(ADDR_POWER_CTRL, POWER_CTRL_RESET);
        $display("halt test done");
        end_of_test();
    end
endmodule // tb_reset_power_ctrl
